//--- rtl/sdp_packer.sv
// serial data packer: byte buffer, frame triggers, apb registers
`timescale 1ns/100ps
module sdp_packer #(
	parameter int TICK_CYCLES = sdp_pkg::TICK_CYC
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic             rx_valid,
	input  wire logic [7:0]       rx_data,
	output logic                  rx_ready,
	output sdp_pkg::sdp_beat_t    tx_beat,
	output logic                  tx_valid,
	input  wire logic             tx_ready
);
	import sdp_pkg::*;

	logic [31:0]  cfg_r;
	logic [15:0]  tmo_r;
	logic [10:0]  len_lim;
	logic [7:0]   mark1;
	logic [7:0]   mark2;
	logic         match2;
	logic [1:0]   trl_mode;
	logic         m1_en;
	logic         m2_en;
	logic         mark_en;

	assign len_lim  = cfg_r[CFG_LEN_LSB +: 11];
	assign mark1    = cfg_r[CFG_M1_LSB +: 8];
	assign mark2    = cfg_r[CFG_M2_LSB +: 8];
	assign match2   = cfg_r[CFG_MATCH2];
	assign trl_mode = cfg_r[CFG_TRL_LSB +: 2];
	assign m1_en    = (mark1 != 8'h00);
	assign m2_en    = (mark2 != 8'h00);
	assign mark_en  = m1_en | m2_en;

	// buffer and frame state
	logic [7:0]   mem [BUF_DEPTH];
	logic [9:0]   wr_ptr_r;
	logic [9:0]   rd_ptr_r;
	logic [10:0]  cnt_r;
	logic [10:0]  frame_len_r;
	logic [10:0]  sent_r;
	sdp_state_t   state_r;
	logic         prev_m1_r;
	logic [1:0]   trl_left_r;
	logic [15:0]  idle_ms_r;
	logic [17:0]  pre_r;
	logic         tick;
	logic         rx_take;
	logic         mark_hit;
	logic         release_now;
	logic [10:0]  cnt_after;
	logic         idle_fire;
	logic         frames_sent_inc;
	logic [15:0]  frame_cnt_r;

	// two-entry output skid buffer
	sdp_beat_t    ob_q [2];
	logic [1:0]   ob_cnt_r;
	logic         ob_wr_ptr_r;
	logic         ob_rd_ptr_r;
	logic         ob_in_ready;
	logic         ob_push;
	logic         ob_pop;
	sdp_beat_t    rd_beat;

	// apb slave: zero wait states, unmapped addresses give slverr
	logic apb_acc;
	assign apb_acc = psel & penable;
	assign pready  = 1'b1;

	always_comb begin
		pslverr = 1'b0;
		if (apb_acc && paddr != ADDR_CFG && paddr != ADDR_TMO && paddr != ADDR_STAT) begin
			pslverr = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cfg_r <= CFG_RST;
			tmo_r <= 16'h0000;
		end else if (apb_acc && pwrite) begin
			if (paddr == ADDR_CFG) begin
				cfg_r <= {2'h0, pwdata[29:0]};
			end else if (paddr == ADDR_TMO) begin
				tmo_r <= pwdata[15:0];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			if (paddr == ADDR_CFG) begin
				prdata <= cfg_r;
			end else if (paddr == ADDR_TMO) begin
				prdata <= {16'h0000, tmo_r};
			end else if (paddr == ADDR_STAT) begin
				prdata <= {frame_cnt_r, 5'h00, cnt_r};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	// millisecond tick; a millisecond is long, so idle timing has one-tick jitter
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pre_r <= 18'h00000;
		end else if (pre_r == 18'(TICK_CYCLES - 1)) begin
			pre_r <= 18'h00000;
		end else begin
			pre_r <= pre_r + 18'h00001;
		end
	end
	assign tick = (pre_r == 18'(TICK_CYCLES - 1));

	assign rx_ready  = (state_r != SDP_DRAIN) && (cnt_r < LEN_MAX);
	assign rx_take   = rx_valid & rx_ready;
	assign cnt_after = cnt_r + 11'h001;

	// marker detection on the incoming byte
	always_comb begin
		mark_hit = 1'b0;
		if (!match2 || !(m1_en && m2_en)) begin
			mark_hit = (m1_en && rx_data == mark1) || (m2_en && rx_data == mark2);
		end else begin
			mark_hit = prev_m1_r && (rx_data == mark2);
		end
	end

	// a byte landing on the tick edge wins over the flush, so it is never split off
	assign idle_fire = (tmo_r != 16'h0000) && (cnt_r != 11'h000) && tick && !rx_take &&
	                   (idle_ms_r >= tmo_r - 16'h0001) && (state_r != SDP_DRAIN);

	always_comb begin
		release_now = 1'b0;
		if (rx_take) begin
			if (!mark_en) begin
				release_now = 1'b1;
			end else if (state_r == SDP_TRAIL && trl_left_r == 2'h1) begin
				release_now = 1'b1;
			end else if (state_r == SDP_COLLECT && mark_hit &&
			             (trl_mode == TRL_NONE || !m1_en)) begin
				release_now = 1'b1;
			end
			if (len_lim != 11'h000 && cnt_after >= len_lim) begin
				release_now = 1'b1;
			end
			if (cnt_after == LEN_MAX) begin
				release_now = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rx_take) begin
			mem[wr_ptr_r] <= rx_data;
		end
	end

	// frame control: collect, wait for trailing bytes, drain
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r     <= SDP_COLLECT;
			prev_m1_r   <= 1'b0;
			trl_left_r  <= 2'h0;
			frame_len_r <= 11'h000;
		end else begin
			case (state_r)
				SDP_COLLECT: begin
					if (release_now || idle_fire) begin
						state_r     <= SDP_DRAIN;
						frame_len_r <= release_now ? cnt_after : cnt_r;
						prev_m1_r   <= 1'b0;
					end else if (rx_take) begin
						prev_m1_r <= (rx_data == mark1) && m1_en;
						if (mark_hit && m1_en) begin
							state_r    <= SDP_TRAIL;
							trl_left_r <= (trl_mode == TRL_PLUS2) ? 2'h2 : 2'h1;
						end
					end
				end
				SDP_TRAIL: begin
					if (release_now || idle_fire) begin
						state_r     <= SDP_DRAIN;
						frame_len_r <= release_now ? cnt_after : cnt_r;
					end else if (rx_take) begin
						trl_left_r <= trl_left_r - 2'h1;
					end
				end
				SDP_DRAIN: begin
					if (ob_push && sent_r == frame_len_r - 11'h001) begin
						state_r    <= SDP_COLLECT;
						prev_m1_r  <= 1'b0;
						trl_left_r <= 2'h0;
					end
				end
				default: begin
					state_r <= SDP_COLLECT;
				end
			endcase
		end
	end

	// idle counter restarts on each byte
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			idle_ms_r <= 16'h0000;
		end else if (rx_take || state_r == SDP_DRAIN) begin
			idle_ms_r <= 16'h0000;
		end else if (tick && idle_ms_r != 16'hffff) begin
			idle_ms_r <= idle_ms_r + 16'h0001;
		end
	end

	assign ob_push = (state_r == SDP_DRAIN) && ob_in_ready;
	assign rd_beat = '{data: mem[rd_ptr_r], last: (sent_r == frame_len_r - 11'h001)};
	assign frames_sent_inc = ob_push & rd_beat.last;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_ptr_r    <= 10'h000;
			rd_ptr_r    <= 10'h000;
			cnt_r       <= 11'h000;
			sent_r      <= 11'h000;
			frame_cnt_r <= 16'h0000;
		end else begin
			if (rx_take) begin
				wr_ptr_r <= wr_ptr_r + 10'h001;
			end
			if (ob_push) begin
				rd_ptr_r <= rd_ptr_r + 10'h001;
				sent_r   <= rd_beat.last ? 11'h000 : sent_r + 11'h001;
			end
			if (frames_sent_inc) begin
				frame_cnt_r <= frame_cnt_r + 16'h0001;
			end
			case ({rx_take, ob_push})
				2'b10:   cnt_r <= cnt_r + 11'h001;
				2'b01:   cnt_r <= cnt_r - 11'h001;
				default: cnt_r <= cnt_r;
			endcase
		end
	end

	assign ob_in_ready = (ob_cnt_r != 2'h2);
	assign ob_pop      = tx_valid & tx_ready;
	assign tx_valid    = (ob_cnt_r != 2'h0);

	always_ff @(posedge clk_sys) begin
		if (ob_push) begin
			ob_q[ob_wr_ptr_r] <= rd_beat;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ob_cnt_r    <= 2'h0;
			ob_wr_ptr_r <= 1'b0;
			ob_rd_ptr_r <= 1'b0;
		end else begin
			if (ob_push) begin
				ob_wr_ptr_r <= ~ob_wr_ptr_r;
			end
			if (ob_pop) begin
				ob_rd_ptr_r <= ~ob_rd_ptr_r;
			end
			case ({ob_push, ob_pop})
				2'b10:   ob_cnt_r <= ob_cnt_r + 2'h1;
				2'b01:   ob_cnt_r <= ob_cnt_r - 2'h1;
				default: ob_cnt_r <= ob_cnt_r;
			endcase
		end
	end

	always_comb begin
		tx_beat = ob_q[ob_rd_ptr_r];
		if (ob_cnt_r == 2'h0) begin
			tx_beat = '{data: 8'h00, last: 1'b0};
		end
	end

	AST_NO_MARK_FWD: assert property (@(posedge clk_sys) disable iff (rst)
		(rx_take && !mark_en && state_r != SDP_DRAIN) |=> (state_r == SDP_DRAIN))
		else $error("byte not forwarded with markers off");
	AST_LEN_LIMIT: assert property (@(posedge clk_sys) disable iff (rst)
		(rx_take && len_lim != 11'h000 && cnt_after == len_lim) |=> (state_r == SDP_DRAIN))
		else $error("length limit not honoured");
	AST_FULL_FLUSH: assert property (@(posedge clk_sys) disable iff (rst)
		(rx_take && cnt_after == LEN_MAX) |=> (state_r == SDP_DRAIN && !rx_ready))
		else $error("full buffer not flushed");
	AST_NO_LIMIT: assert property (@(posedge clk_sys) disable iff (rst)
		(state_r == SDP_COLLECT && rx_take && len_lim == 11'h000 && mark_en && !mark_hit
		 && cnt_after < LEN_MAX && !idle_fire) |=> (state_r == SDP_COLLECT))
		else $error("frame released without cause");
	AST_TRAIL_ENTRY: assert property (@(posedge clk_sys) disable iff (rst)
		(state_r == SDP_COLLECT && rx_take && mark_hit && m1_en && trl_mode == TRL_PLUS2
		 && !release_now && !idle_fire) |=> (state_r == SDP_TRAIL && trl_left_r == 2'h2))
		else $error("trailing wait not armed");
	AST_TRAIL_DONE: assert property (@(posedge clk_sys) disable iff (rst)
		(state_r == SDP_TRAIL && rx_take && trl_left_r == 2'h1) |=> (state_r == SDP_DRAIN))
		else $error("trailing bytes not released");
	AST_IDLE_OFF: assert property (@(posedge clk_sys) disable iff (rst)
		(tmo_r == 16'h0000 && state_r == SDP_COLLECT && !rx_take)
		|=> (state_r == SDP_COLLECT))
		else $error("idle flush with timeout off");
	AST_MATCH_CLR: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(state_r == SDP_DRAIN) |-> (!prev_m1_r && trl_left_r == 2'h0 && sent_r == 11'h000))
		else $error("matching state not cleared");
	AST_OB_FULL: assert property (@(posedge clk_sys) disable iff (rst)
		(ob_cnt_r == 2'h2 && !tx_ready) |=> (ob_cnt_r == 2'h2 && $stable(tx_beat)))
		else $error("output buffer lost a word");
	AST_TX_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
		(tx_valid && !tx_ready) |=> (tx_valid && $stable(tx_beat)))
		else $error("stalled output word changed");
	AST_PAIR_ORDER: assert property (@(posedge clk_sys) disable iff (rst)
		(state_r == SDP_COLLECT && rx_take && match2 && m1_en && m2_en && !prev_m1_r
		 && len_lim == 11'h000 && cnt_after < LEN_MAX) |=> (state_r == SDP_COLLECT))
		else $error("marker pair matched out of order");
	AST_EITHER_MARK: assert property (@(posedge clk_sys) disable iff (rst)
		(state_r == SDP_COLLECT && rx_take && !match2 && m2_en && rx_data == mark2
		 && (trl_mode == TRL_NONE || !m1_en)) |=> (state_r == SDP_DRAIN))
		else $error("single marker did not release");
	AST_TRAIL_WAIT: assert property (@(posedge clk_sys) disable iff (rst)
		(state_r == SDP_TRAIL && rx_take && trl_left_r == 2'h2 && mark_en
		 && len_lim == 11'h000 && cnt_after < LEN_MAX)
		|=> (state_r == SDP_TRAIL && trl_left_r == 2'h1))
		else $error("trailing byte released too early");
	AST_IDLE_FLUSH: assert property (@(posedge clk_sys) disable iff (rst)
		(state_r == SDP_COLLECT && tick && !rx_take && tmo_r != 16'h0000
		 && cnt_r != 11'h000 && idle_ms_r == tmo_r - 16'h0001)
		|=> (state_r == SDP_DRAIN && frame_len_r == $past(cnt_r)))
		else $error("idle flush missing");
endmodule : sdp_packer

//--- rtl/sdp_pkg.sv
// constants and carrier types for the serial data packer
// Overview of operation
// - length limit zero means no limit; release only on marker, idle timeout or full buffer, or on every byte with markers off
// - length limit 1..1024 releases the frame when the count reaches it
// - markers hold 00..ff; with no marker each byte is forwarded at once
// - with a marker enabled, accumulate until the marker condition, then release all
// - second marker zero uses only the first; both zero disables markers
// - a full 1k buffer is released as a frame and emptied
// - match count one: either marker alone completes the condition
// - match count two (default): first marker immediately followed by second
// - trailing mode needs first marker; with both, both precede trailing bytes at match count two, either one at match count one
// - trailing mode none releases right at marker completion
// - plus-one or plus-two modes wait for that many further bytes, then release
// - idle timeout zero disables the idle flush
// - idle timeout 1..65535 ms flushes when no byte arrives in that time
package sdp_pkg;
	localparam int          CLK_MHZ      = 250;
	localparam int          TICK_MS      = 1;
	localparam int          TICK_CYC     = CLK_MHZ * 1000 * TICK_MS;
	localparam int          BUF_DEPTH    = 1024;
	localparam logic [10:0] LEN_MAX      = 11'h400;
	localparam logic [11:0] ADDR_CFG     = 12'h000;
	localparam logic [11:0] ADDR_TMO     = 12'h004;
	localparam logic [11:0] ADDR_STAT    = 12'h008;
	localparam int          CFG_LEN_LSB  = 0;
	localparam int          CFG_M1_LSB   = 11;
	localparam int          CFG_M2_LSB   = 19;
	localparam int          CFG_MATCH2   = 27;
	localparam int          CFG_TRL_LSB  = 28;
	localparam logic [31:0] CFG_RST      = 32'h0800_0000;
	localparam logic [1:0]  TRL_NONE     = 2'h0;
	localparam logic [1:0]  TRL_PLUS1    = 2'h1;
	localparam logic [1:0]  TRL_PLUS2    = 2'h2;

	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} sdp_beat_t;

	typedef enum logic [1:0] {
		SDP_COLLECT = 2'b00,
		SDP_TRAIL   = 2'b01,
		SDP_DRAIN   = 2'b10
	} sdp_state_t;
endpackage : sdp_pkg

//--- test/sdp_host_model.sv
// host serial source model feeding the packer receive side
`timescale 1ns/100ps
module sdp_host_model (
	input  wire logic       clk_sys,
	input  wire logic       rx_ready,
	output logic            rx_valid,
	output logic [7:0]      rx_data
);
	initial begin
		rx_valid = 1'b0;
		rx_data  = 8'h00;
	end

	// idle data is inverted so a stale byte can never pass as valid
	task automatic send(input logic [7:0] b[$], input int gap, output bit ok);
		int n;
		ok = 1'b1;
		foreach (b[i]) begin
			rx_valid <= 1'b1;
			rx_data  <= b[i];
			n = 0;
			do begin
				@(posedge clk_sys);
				n++;
			end while (rx_ready !== 1'b1 && n < 5000);
			if (rx_ready !== 1'b1)
				ok = 1'b0;
			// gaps kept far below any idle timeout the bench sets
			if (gap > 0) begin
				rx_valid <= 1'b0;
				rx_data  <= ~b[i];
				repeat (gap) @(posedge clk_sys);
			end
		end
		if (gap == 0) begin
			rx_valid <= 1'b0;
			rx_data  <= ~b[b.size()-1];
		end
	endtask : send
endmodule : sdp_host_model

//--- test/serial_data_packer_tb_top.sv
// self-checking bench for the serial data packer
`timescale 1ns/100ps
module serial_data_packer_tb_top;
	import sdp_pkg::*;
	localparam int TICK = 20;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, rx_valid, rx_ready, tx_valid;
	logic [7:0]  rx_data;
	logic        tx_ready = 1'b0;
	sdp_beat_t   tx_beat;
	logic [1:0]  cyc = 2'h0;
	int          err_count = 0;
	int          num_checks = 0;
	int          cur = 0;
	int          frames = 0;
	logic [7:0]  got_q[$];
	logic [7:0]  sent_q[$];
	int          flen_q[$];

	always #2 clk_sys = ~clk_sys;

	sdp_packer #(.TICK_CYCLES(TICK)) u_dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_data, .rx_ready, .tx_beat,
		.tx_valid, .tx_ready);
	sdp_host_model u_host (.clk_sys, .rx_ready, .rx_valid, .rx_data);

	// sink stalls one cycle in four so the output buffer must hold words
	always @(posedge clk_sys) begin
		cyc      <= cyc + 2'h1;
		tx_ready <= (cyc != 2'h3);
		if (!rst && tx_valid === 1'b1 && tx_ready) begin
			got_q.push_back(tx_beat.data);
			cur++;
			if (tx_beat.last === 1'b1) begin
				flen_q.push_back(cur);
				cur = 0;
			end
		end
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			err_count++;
			stop_test();
		end
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask : wr

	task automatic rd(input string what, input logic [11:0] a, input logic [31:0] m,
			input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(what, q & m, exp);
		chk({what, " slverr"}, {31'h0, e}, {31'h0, (a > ADDR_STAT)});
	endtask : rd

	task automatic cfg(input logic [10:0] len, input logic [7:0] m1, input logic [7:0] m2,
			input logic two, input logic [1:0] trl);
		wr(ADDR_CFG, {2'h0, trl, two, m2, m1, len});
	endtask : cfg

	task automatic run(input string what, input logic [7:0] b[$], input int gap, input int lens[$]);
		bit ok;
		int n;
		u_host.send(b, gap, ok);
		sent_q = {sent_q, b};
		chk({what, " accepted"}, {31'h0, ok}, 32'h1);
		n = 0;
		while (flen_q.size() < lens.size() && n < 3000) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 3000) begin
			err_count++;
			stop_test();
		end
		// extra frames would show up here
		repeat (20) @(posedge clk_sys);
		chk({what, " frames"}, flen_q.size(), lens.size());
		foreach (lens[i])
			if (i < flen_q.size())
				chk({what, " length"}, flen_q[i], lens[i]);
		foreach (got_q[i])
			chk({what, " data"}, got_q[i], sent_q.pop_front());
		frames += flen_q.size();
		flen_q.delete();
		got_q.delete();
		$display("test %s done", what);
	endtask : run

	initial begin
		logic [7:0] big[$];
		int         none[$];
		for (int i = 0; i < 1024; i++)
			big.push_back(8'h55);
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		rd("cfg reset", ADDR_CFG, 32'hffff_ffff, CFG_RST);
		rd("tmo reset", ADDR_TMO, 32'hffff_ffff, 32'h0);
		rd("unmapped", 12'h00c, 32'hffff_ffff, 32'h0);
		cfg(11'h0, 8'h00, 8'h00, 1'b1, TRL_NONE);
		run("no marker", '{8'h41, 8'h0d, 8'h42}, 0, '{1, 1, 1});
		cfg(11'h3, 8'h0d, 8'h00, 1'b1, TRL_NONE);
		run("length", '{8'h1, 8'h2, 8'h3, 8'h4, 8'h5, 8'h6}, 0, '{3, 3});
		cfg(11'h0, 8'h0d, 8'h00, 1'b1, TRL_NONE);
		run("one marker", '{8'h41, 8'h42, 8'h0d, 8'h43, 8'h0d}, 1, '{3, 2});
		cfg(11'h0, 8'h0d, 8'h0a, 1'b1, TRL_NONE);
		run("pair", '{8'h0a, 8'h0d, 8'h41, 8'h0d, 8'h0a}, 0, '{5});
		cfg(11'h0, 8'h0d, 8'h0a, 1'b0, TRL_NONE);
		run("either", '{8'h41, 8'h0a, 8'h42, 8'h0d}, 0, '{2, 2});
		cfg(11'h0, 8'h0d, 8'h00, 1'b1, TRL_PLUS2);
		run("trail two", '{8'h41, 8'h0d, 8'h42, 8'h43, 8'h0d, 8'h44, 8'h45}, 0, '{4, 3});
		cfg(11'h0, 8'h00, 8'h0d, 1'b0, TRL_PLUS1);
		run("trail no m1", '{8'h41, 8'h0d}, 0, '{2});
		cfg(11'h0, 8'h0d, 8'h00, 1'b1, TRL_NONE);
		run("no idle", '{8'h41, 8'h42}, 1, none);
		repeat (300) @(posedge clk_sys);
		chk("no idle frames", flen_q.size(), 0);
		rd("stat count", ADDR_STAT, 32'h0000_07ff, 32'h2);
		wr(ADDR_TMO, 32'h3);
		// the two stale bytes have waited long past the timeout: they go on the next tick
		repeat (30) @(posedge clk_sys);
		run("idle", '{8'h43}, 1, '{2, 1});
		wr(ADDR_TMO, 32'h0);
		run("full", big, 0, '{1024});
		rd("frame count", ADDR_STAT, 32'hffff_0000, frames << 16);
		stop_test();
	end
endmodule : serial_data_packer_tb_top
